//--- rtl/dram_strobe_and_rom_select.sv
`timescale 1ns/1ns
`default_nettype none
`include "dram_strobe_cfg.svh"
// Function
// - Upper column strobe high byte, lower low.
// - Both column strobes active during refresh.
// - Row/column select high for row address.
// - Read/write line high read, low write.
// - Read/write line held high during refresh.
// - First and second row strobes latch rows.
// - Both row strobes asserted during refresh outside address mode.
// - Second row strobe may become address bit.
// - Config bit six exchanges row strobe pins.
// - ROM select low reading F00000 to FFFFFF.
module dram_strobe_and_rom_select (
   input wire logic CLOCK,
   input wire logic RST,
   input wire logic MEM_REQ,
   input wire logic MEM_WRITE,
   input wire logic [1:0] BYTE_EN,
   input wire logic ROW_SEL,
   input wire logic ADDR_BIT,
   input wire logic REF_REQ,
   input wire logic [23:0] BUS_ADDR,
   input wire logic BUS_READ,
   input wire logic BUS_STROBE,
   input wire logic EXTRA_ADDR_MODE,
   input wire logic [7:0] TEST_CONFIG,
   output logic MEM_DONE,
   output logic UPPER_COL_STROBE_N,
   output logic LOWER_COL_STROBE_N,
   output logic ROW_COL_SELECT,
   output logic DRAM_RD_WR_N,
   output logic FIRST_ROW_STROBE_N,
   output logic SECOND_ROW_STROBE_N,
   output logic ROM_SELECT_N
);
   // ****************************************************************
   // Sequencer state and latched request.
   // ****************************************************************
   dram_strobe_pkg::state_type state_reg; // Current state.
   dram_strobe_pkg::strobe_type strobe_reg; // Active-high strobes.
   logic write_reg; // Latched write flag.
   logic [1:0] lanes_reg; // Latched byte lanes.
   logic row_sel_reg; // Latched row choice.
   logic addr_bit_reg; // Latched extra row address bit.
   logic [1:0] step_reg; // Dwell counter.

   // Decodes the ROM window; used by the select and the checks.
   function automatic logic in_rom(input logic [23:0] a);
      in_rom = (a >= `ROM_BASE_ADDR) && (a <= `ROM_LAST_ADDR);
   endfunction

   // Sequencer: refresh has priority over an access.
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         state_reg <= dram_strobe_pkg::IDLE;
         step_reg <= 2'h0;
      end else begin
         case (state_reg)
            dram_strobe_pkg::IDLE: begin
               if (REF_REQ) begin
                  state_reg <= dram_strobe_pkg::REF_CAS;
               end else if (MEM_REQ) begin
                  state_reg <= dram_strobe_pkg::ROW;
               end
            end
            dram_strobe_pkg::ROW: begin
               state_reg <= dram_strobe_pkg::COL;
            end
            dram_strobe_pkg::COL: begin
               state_reg <= dram_strobe_pkg::HOLD;
               step_reg <= 2'(`STEP_CYCLES);
            end
            dram_strobe_pkg::HOLD: begin
               // Column strobes held for the dwell time.
               if (step_reg <= 2'h1) begin
                  state_reg <= dram_strobe_pkg::IDLE;
               end else begin
                  step_reg <= step_reg - 2'h1;
               end
            end
            dram_strobe_pkg::REF_CAS: begin
               state_reg <= dram_strobe_pkg::REF_RAS;
            end
            dram_strobe_pkg::REF_RAS: begin
               state_reg <= dram_strobe_pkg::REF_END;
            end
            dram_strobe_pkg::REF_END: begin
               state_reg <= dram_strobe_pkg::IDLE;
            end
            default: begin
               state_reg <= dram_strobe_pkg::IDLE;
            end
         endcase
      end
   end

   // Request fields captured when an access begins.
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         write_reg <= 1'b0;
         lanes_reg <= 2'h0;
         row_sel_reg <= 1'b0;
         addr_bit_reg <= 1'b0;
      end else if (state_reg == dram_strobe_pkg::IDLE && MEM_REQ && !REF_REQ) begin
         write_reg <= MEM_WRITE;
         lanes_reg <= BYTE_EN;
         row_sel_reg <= ROW_SEL;
         addr_bit_reg <= ADDR_BIT;
      end
   end

   // Internal strobes decoded from the state.
   always_comb begin
      strobe_reg = '0;
      case (state_reg)
         dram_strobe_pkg::ROW, dram_strobe_pkg::COL: begin
            // Column strobes wait a cycle so the select has switched before they fall.
            strobe_reg.row_a = EXTRA_ADDR_MODE | ~row_sel_reg;
            strobe_reg.row_b = ~EXTRA_ADDR_MODE & row_sel_reg;
         end
         dram_strobe_pkg::HOLD: begin
            strobe_reg.row_a = EXTRA_ADDR_MODE | ~row_sel_reg;
            strobe_reg.row_b = ~EXTRA_ADDR_MODE & row_sel_reg;
            strobe_reg.col_hi = lanes_reg[1];
            strobe_reg.col_lo = lanes_reg[0];
         end
         dram_strobe_pkg::REF_CAS: begin
            strobe_reg.col_hi = 1'b1;
            strobe_reg.col_lo = 1'b1;
         end
         dram_strobe_pkg::REF_RAS: begin
            strobe_reg = '1;
         end
         dram_strobe_pkg::REF_END: begin
            // Column strobes released first, rows last.
            strobe_reg.row_a = 1'b1;
            strobe_reg.row_b = 1'b1;
         end
         default: begin
            strobe_reg = '0;
         end
      endcase
   end

   // ****************************************************************
   // Registered DRAM pins.
   // ****************************************************************
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         UPPER_COL_STROBE_N <= 1'b1;
         LOWER_COL_STROBE_N <= 1'b1;
         ROW_COL_SELECT <= 1'b1;
         DRAM_RD_WR_N <= 1'b1;
         MEM_DONE <= 1'b0;
      end else begin
         UPPER_COL_STROBE_N <= ~strobe_reg.col_hi;
         LOWER_COL_STROBE_N <= ~strobe_reg.col_lo;
         // Low from the column state; high again in idle for the next row.
         ROW_COL_SELECT <= !(state_reg == dram_strobe_pkg::COL ||
            state_reg == dram_strobe_pkg::HOLD);
         // Write level only in an access; refresh keeps the read level.
         DRAM_RD_WR_N <= !(write_reg && (state_reg == dram_strobe_pkg::COL ||
            state_reg == dram_strobe_pkg::HOLD));
         MEM_DONE <= state_reg == dram_strobe_pkg::HOLD && step_reg <= 2'h1;
      end
   end

   // ROM select on reads of the ROM window.
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         ROM_SELECT_N <= 1'b1;
      end else begin
         ROM_SELECT_N <= !(BUS_STROBE && BUS_READ && in_rom(BUS_ADDR));
      end
   end

   // Row pin routing, address mode and exchange.
   row_pin_router router (
      .CLOCK(CLOCK),
      .RST(RST),
      .row_a(strobe_reg.row_a),
      .row_b(strobe_reg.row_b),
      .extra_bit(addr_bit_reg),
      .addr_mode(EXTRA_ADDR_MODE),
      .swap(TEST_CONFIG[`ROW_SWAP_BIT]),
      .first_pin_n(FIRST_ROW_STROBE_N),
      .second_pin_n(SECOND_ROW_STROBE_N)
   );

   // ****************************************************************
   // Checks.
   // ****************************************************************
   rom_read_a: assert property (@(posedge CLOCK) disable iff (RST)
      (BUS_STROBE && BUS_READ && in_rom(BUS_ADDR)) |=> !ROM_SELECT_N)
      else $error("ROM select missing on ROM read.");
   rom_idle_a: assert property (@(posedge CLOCK) disable iff (RST)
      !(BUS_STROBE && BUS_READ && in_rom(BUS_ADDR)) |=> ROM_SELECT_N)
      else $error("ROM select outside ROM read.");
   refresh_read_a: assert property (@(posedge CLOCK) disable iff (RST)
      (state_reg == dram_strobe_pkg::REF_CAS) |=> DRAM_RD_WR_N [*3])
      else $error("Write level during refresh.");
   refresh_cas_a: assert property (@(posedge CLOCK) disable iff (RST)
      (state_reg == dram_strobe_pkg::REF_CAS) |=> !UPPER_COL_STROBE_N && !LOWER_COL_STROBE_N)
      else $error("Column strobes idle in refresh.");
   cas_first_a: assert property (@(posedge CLOCK) disable iff (RST)
      (state_reg == dram_strobe_pkg::REF_CAS && !EXTRA_ADDR_MODE) |=>
      (FIRST_ROW_STROBE_N && SECOND_ROW_STROBE_N && !LOWER_COL_STROBE_N))
      else $error("Row strobe before column in refresh.");
   refresh_ras_a: assert property (@(posedge CLOCK) disable iff (RST)
      (state_reg == dram_strobe_pkg::REF_RAS && !EXTRA_ADDR_MODE) |=>
      (!FIRST_ROW_STROBE_N && !SECOND_ROW_STROBE_N))
      else $error("Row strobes idle in refresh.");
   release_order_a: assert property (@(posedge CLOCK) disable iff (RST)
      (state_reg == dram_strobe_pkg::REF_END && !EXTRA_ADDR_MODE) |=>
      (UPPER_COL_STROBE_N && LOWER_COL_STROBE_N && !FIRST_ROW_STROBE_N))
      else $error("Refresh strobes released out of order.");
   mux_before_col_a: assert property (@(posedge CLOCK) disable iff (RST)
      $fell(ROW_COL_SELECT) |-> (UPPER_COL_STROBE_N && LOWER_COL_STROBE_N))
      else $error("Column strobe falls with the select switch.");
   mux_order_a: assert property (@(posedge CLOCK) disable iff (RST)
      (state_reg == dram_strobe_pkg::ROW) |=> ROW_COL_SELECT ##1 !ROW_COL_SELECT)
      else $error("Select not switching between row and column.");
   write_level_a: assert property (@(posedge CLOCK) disable iff (RST)
      (state_reg == dram_strobe_pkg::COL && write_reg) |=> !DRAM_RD_WR_N)
      else $error("Write level missing.");
   upper_lane_a: assert property (@(posedge CLOCK) disable iff (RST)
      (state_reg == dram_strobe_pkg::HOLD) |=> (UPPER_COL_STROBE_N == !$past(lanes_reg[1])))
      else $error("Upper column strobe wrong lane.");
   access_c: cover property (@(posedge CLOCK) state_reg == dram_strobe_pkg::HOLD);
   refresh_c: cover property (@(posedge CLOCK) state_reg == dram_strobe_pkg::REF_END);
   rom_c: cover property (@(posedge CLOCK) !ROM_SELECT_N);
endmodule
`default_nettype wire

//--- rtl/dram_strobe_cfg.svh
`ifndef DRAM_STROBE_CFG_SVH
`define DRAM_STROBE_CFG_SVH
// ****************************************************************
// Address window of the on-board ROM.
// ****************************************************************
`define ROM_BASE_ADDR 24'hF0_0000
`define ROM_LAST_ADDR 24'hFF_FFFF
// ****************************************************************
// Bit of the test configuration word that exchanges the row strobes.
// ****************************************************************
`define ROW_SWAP_BIT 6
// ****************************************************************
// Time the column address is held after the multiplexer switches.
// ****************************************************************
`define STEP_TIME_NS 100
`define CLOCK_PERIOD_NS 100
`define STEP_CYCLES ((`STEP_TIME_NS + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS)
`endif

//--- rtl/dram_strobe_pkg.sv
// ****************************************************************
// Types used by the strobe sequencer; its pin router takes plain bits.
// ****************************************************************
package dram_strobe_pkg;
   // Sequencer states.
   typedef enum logic [2:0] {
      IDLE = 3'b000,
      ROW = 3'b001,
      COL = 3'b010,
      HOLD = 3'b011,
      REF_CAS = 3'b100,
      REF_RAS = 3'b101,
      REF_END = 3'b110
   } state_type;
   // Active-high internal strobe set before pin routing.
   typedef struct packed {
      logic row_a;
      logic row_b;
      logic col_hi;
      logic col_lo;
   } strobe_type;
endpackage

//--- rtl/row_pin_router.sv
`timescale 1ns/1ns
`default_nettype none
// ****************************************************************
// Maps internal row strobes to the two row pins.
// ****************************************************************
module row_pin_router (
   input wire logic CLOCK,
   input wire logic RST,
   input wire logic row_a,
   input wire logic row_b,
   input wire logic extra_bit,
   input wire logic addr_mode,
   input wire logic swap,
   output logic first_pin_n,
   output logic second_pin_n
);
   // Second pin level before any exchange.
   logic second_level;
   always_comb begin
      // In address mode the second pin carries the extra row address bit.
      if (addr_mode) begin
         second_level = extra_bit;
      end else begin
         second_level = ~row_b;
      end
   end
   // Pins come from flip-flops; exchange applied here.
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         first_pin_n <= 1'b1;
         second_pin_n <= 1'b1;
      end else if (swap) begin
         first_pin_n <= second_level;
         second_pin_n <= ~row_a;
      end else begin
         first_pin_n <= ~row_a;
         second_pin_n <= second_level;
      end
   end
endmodule
`default_nettype wire

//--- verif/dram_far_side.sv
`timescale 1ns/1ns
`default_nettype none
// ****************************************************************
// Far-side DRAM model.
// ****************************************************************
// It records the byte lanes and row pins seen at each column latch.
module dram_far_side (
   input wire logic CLOCK,
   input wire logic RST,
   input wire logic [1:0] col_n,
   input wire logic [1:0] row_n,
   input wire logic sel,
   output logic [1:0] lanes,
   output logic [1:0] rows,
   output logic [7:0] refreshes,
   output logic bad_sel
);
   logic [1:0] col_n_reg; // Column strobes one cycle ago.
   // A falling column strobe latches a column, or starts a refresh when rows are idle.
   always_ff @(posedge CLOCK) begin
      col_n_reg <= col_n;
      if (RST) begin
         refreshes <= 8'h00;
         lanes <= 2'h0;
         rows <= 2'h0;
         bad_sel <= 1'h0;
      end else if ((col_n_reg & ~col_n) != 2'h0) begin
         if (row_n == 2'h3) begin
            refreshes <= refreshes + 8'h01;
         end else begin
            lanes <= ~col_n;
            rows <= ~row_n;
            bad_sel <= sel;
         end
      end
   end
endmodule
`default_nettype wire

//--- verif/dram_strobe_and_rom_select_tb.sv
`timescale 1ns/1ns
`default_nettype none
// ****************************************************************
// Bench for the strobe sequencer.
// ****************************************************************
module dram_strobe_and_rom_select_tb;
   logic clock, rst, req, wr, rs, abit, rreq, brd, bstb, amode, done;
   logic [1:0] be, lanes, rows;
   logic [23:0] addr;
   logic [7:0] cfg, refs;
   logic up_n, lo_n, rcs, rdwr_n, r1_n, r2_n, rom_n, bad;
   int miscompares = 0; // Mismatches seen.
   int total_checks = 0; // Comparisons made.
   dram_strobe_and_rom_select i_dut (.CLOCK(clock), .RST(rst), .MEM_REQ(req),
      .MEM_WRITE(wr), .BYTE_EN(be), .ROW_SEL(rs), .ADDR_BIT(abit), .REF_REQ(rreq),
      .BUS_ADDR(addr), .BUS_READ(brd), .BUS_STROBE(bstb), .EXTRA_ADDR_MODE(amode),
      .TEST_CONFIG(cfg), .MEM_DONE(done), .UPPER_COL_STROBE_N(up_n),
      .LOWER_COL_STROBE_N(lo_n), .ROW_COL_SELECT(rcs), .DRAM_RD_WR_N(rdwr_n),
      .FIRST_ROW_STROBE_N(r1_n), .SECOND_ROW_STROBE_N(r2_n), .ROM_SELECT_N(rom_n));
   dram_far_side i_far (.CLOCK(clock), .RST(rst), .col_n({up_n, lo_n}),
      .row_n({r2_n, r1_n}), .sel(rcs), .lanes(lanes), .rows(rows),
      .refreshes(refs), .bad_sel(bad));
   // The clock runs at 10 MHz.
   initial begin
      clock = 1'h0;
      forever #50 clock = ~clock;
   end
   // Prints the counts and the verdict, then ends the run.
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // Compares one output bit.
   task automatic check_bit(string name, logic exp, logic got);
      total_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] %s expected %b seen %b", name, exp, got);
      end
   endtask
   // Compares a small vector.
   task automatic check_vec(string name, logic [7:0] exp, logic [7:0] got);
      total_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", name, exp, got);
      end
   endtask
   // Waits on falling edges until done goes high (lower column strobe low when on_done is low) or the bound runs out.
   task automatic wait_col(logic on_done);
      int n;
      n = 0;
      while ((on_done ? done : ~lo_n) !== 1'h1) begin
         @(negedge clock);
         n++;
         if (n > 20) begin
            miscompares++;
            report_and_stop();
         end
      end
   endtask
   // One access; e1 and e2 are the expected row pin levels.
   task automatic access(logic w, logic [1:0] b, logic s, logic e1, logic e2);
      @(posedge clock);
      wr <= w;
      be <= b;
      rs <= s;
      req <= 1'h1;
      @(posedge clock);
      req <= 1'h0;
      wait_col(1'h1);
      check_bit("upper col", ~b[1], up_n);
      check_bit("lower col", ~b[0], lo_n);
      check_bit("select col", 1'h0, rcs);
      check_bit("rd wr", ~w, rdwr_n);
      check_bit("first row", e1, r1_n);
      check_bit("second row", e2, r2_n);
      @(negedge clock);
      check_vec("lanes", {6'h00, b}, {6'h00, lanes});
      check_vec("rows", {6'h00, ~e2, ~e1}, {6'h00, rows});
      check_bit("select at latch", 1'h0, bad);
      @(negedge clock);
      check_bit("select row", 1'h1, rcs);
      check_bit("col idle", 1'h1, up_n & lo_n);
   endtask
   // One refresh; n is the expected refresh count afterwards.
   task automatic refresh(logic [7:0] n);
      @(posedge clock);
      rreq <= 1'h1;
      @(posedge clock);
      rreq <= 1'h0;
      wait_col(1'h0);
      check_bit("ref upper col", 1'h0, up_n);
      check_bit("ref rows idle", 1'h1, r1_n & r2_n);
      check_bit("ref rd wr", 1'h1, rdwr_n);
      @(negedge clock);
      check_bit("ref first row", 1'h0, r1_n);
      check_bit("ref second row", 1'h0, r2_n);
      check_bit("ref rd wr late", 1'h1, rdwr_n);
      @(negedge clock);
      check_bit("ref col release", 1'h1, up_n & lo_n);
      check_bit("ref rows held", 1'h0, r1_n | r2_n);
      repeat (2) @(negedge clock);
      check_vec("refreshes", n, refs);
   endtask
   // One bus cycle seen by the ROM decode.
   task automatic rom_case(logic [23:0] a, logic rd, logic exp);
      @(posedge clock);
      addr <= a;
      brd <= rd;
      bstb <= 1'h1;
      @(posedge clock);
      @(negedge clock);
      check_bit("rom select", exp, rom_n);
      @(posedge clock);
      bstb <= 1'h0;
   endtask
   // Main sequence.
   initial begin
      {rst, req, wr, rs, abit, rreq, brd, bstb, amode} = 9'h100;
      be = 2'h0;
      addr = 24'h00_0000;
      cfg = 8'h00;
      repeat (20) @(posedge clock);
      rst <= 1'h0;
      access(1'h0, 2'h3, 1'h0, 1'h0, 1'h1);
      access(1'h1, 2'h2, 1'h1, 1'h1, 1'h0);
      access(1'h0, 2'h1, 1'h0, 1'h0, 1'h1);
      @(posedge clock);
      cfg <= 8'h40;
      access(1'h1, 2'h3, 1'h0, 1'h1, 1'h0);
      @(posedge clock);
      cfg <= 8'h00;
      amode <= 1'h1;
      abit <= 1'h1;
      access(1'h0, 2'h3, 1'h1, 1'h0, 1'h1);
      @(posedge clock);
      abit <= 1'h0;
      access(1'h0, 2'h3, 1'h1, 1'h0, 1'h0);
      @(posedge clock);
      amode <= 1'h0;
      refresh(8'h01);
      refresh(8'h02);
      rom_case(24'hEF_FFFF, 1'h1, 1'h1);
      rom_case(24'hF0_0000, 1'h1, 1'h0);
      rom_case(24'hFF_FFFF, 1'h1, 1'h0);
      rom_case(24'hF0_0000, 1'h0, 1'h1);
      report_and_stop();
   end
endmodule
`default_nettype wire
